/* File: supply_ctrl_pkg.sv */
// Constants for the supply monitor and regulator control block
package supply_ctrl_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_UNLOCK    = 6'h00;
  localparam logic [5:0] OFS_VREG      = 6'h04;
  localparam logic [5:0] OFS_MONITOR   = 6'h08;
  localparam logic [5:0] OFS_TSENSOR   = 6'h0c;
  localparam logic [5:0] OFS_FAST_OSC  = 6'h10;
  localparam logic [5:0] OFS_SLOW_OSC  = 6'h14;
  localparam logic [5:0] OFS_PWR_STAT  = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN    = 6'h1c;
  localparam logic [5:0] OFS_IRQ_DIS   = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK  = 6'h24;
  localparam logic [5:0] OFS_IRQ_STAT  = 6'h28;
  localparam logic [5:0] OFS_IRQ_CLR   = 6'h2c;
  // Unlock key in bits 31:24, target offset in bits 5:0
  localparam logic [7:0] UNLOCK_KEY    = 8'haa;
  // Regulator control register fields
  localparam int VR_EN      = 0;
  localparam int VR_ON      = 1;
  localparam int VR_SEL_LO  = 2;
  localparam int VR_GOOD    = 4;
  localparam int VR_CAL_LO  = 8;
  localparam int VR_FCD     = 16;
  localparam int VR_HV_EN   = 17;
  localparam int VR_HV_ST   = 18;
  localparam int VR_HV_MSK  = 19;
  localparam int VR_HV_MST  = 20;
  localparam int FREEZE_BIT = 31;
  // Supply monitor register fields
  localparam int SM_CTRL_LO = 0;
  localparam int SM_FS      = 4;
  localparam int SM_RATE_LO = 8;
  localparam int SM_CAL_LO  = 16;
  localparam int SM_FCD     = 24;
  localparam int SM_ON      = 25;
  // Status and interrupt bit positions
  localparam int ST_ERR     = 0;
  localparam int ST_DROP    = 1;
  localparam int ST_GOOD    = 2;
  // Reset values and monitor control codes
  localparam logic [1:0] SEL_1V8_RST  = 2'h0;
  localparam logic [1:0] CTRL_OFF     = 2'h0;
  localparam logic [1:0] CTRL_RESET   = 2'h1;
  localparam logic [1:0] CTRL_IRQ     = 2'h2;
  localparam int         SYNC_DLY_RST = 2;
  // Calibration sequencer states
  typedef enum logic {CAL_LOAD, CAL_RUN} cal_state_e;
endpackage : supply_ctrl_pkg

/* File: supply_monitor_regulator_ctrl.sv */
// Regulator, supply monitor and oscillator enable control with Avalon-MM registers
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regulator_ctrl #(
  parameter int CAL_W    = 8,
  parameter int RATE_W   = 4,
  parameter int SYNC_DLY = supply_ctrl_pkg::SYNC_DLY_RST
) (
  input  wire  logic              clk_in,
  input  wire  logic              resetn_in,
  input  wire  logic              por_resetn_in,
  input  wire  logic [5:0]        address_in,
  input  wire  logic              read_in,
  input  wire  logic              write_in,
  input  wire  logic [31:0]       writedata_in,
  output logic [31:0]             readdata_out,
  output logic                    waitrequest_out,
  input  wire  logic [CAL_W-1:0]  fuse_vreg_cal_in,
  input  wire  logic [CAL_W-1:0]  fuse_mon_cal_in,
  input  wire  logic              wake_shutdown_in,
  input  wire  logic              regulator_good_in,
  input  wire  logic              hv_trip_in,
  input  wire  logic              supply_low_in,
  input  wire  logic              deep_halt_sleep_in,
  input  wire  logic              slow_tick_in,
  output logic                    cpu_run_out,
  output logic                    regulator_en_out,
  output logic [1:0]              output_level_select_out,
  output logic [CAL_W-1:0]        vreg_cal_out,
  output logic                    hv_detector_en_out,
  output logic                    monitor_en_out,
  output logic                    sampling_mode_out,
  output logic                    sample_strobe_out,
  output logic [CAL_W-1:0]        mon_cal_out,
  output logic                    slow_osc_en_out,
  output logic                    temp_sensor_en_out,
  output logic                    fast_osc_en_out,
  output logic                    reset_req_out,
  output logic                    irq_out
);
  import supply_ctrl_pkg::*;

  // Power-on domain state
  logic              vreg_en_ff, vreg_frz_ff, vreg_fcd_ff, hv_en_ff, hv_mask_ff;
  logic [1:0]        sel_ff;
  logic [CAL_W-1:0]  vreg_cal_ff;
  // Ordinary reset domain state
  logic              mon_frz_ff, mon_fcd_ff, mon_fs_ff, temp_en_ff, fosc_en_ff, sosc_en_ff;
  logic [1:0]        mon_ctrl_ff;
  logic [RATE_W-1:0] mon_rate_ff;
  logic [CAL_W-1:0]  mon_cal_ff;
  logic              unlock_ff;                 // Unlock armed
  logic [5:0]        unlock_ofs_ff;             // Offset it was armed for
  logic              wait_ff;                   // Bus wait state
  logic [31:0]       rdata_ff;                  // Read data
  logic              drop_ff, good_ff, hv_eff_ff, samp_ff, strobe_ff, rst_req_ff, irq_ff;
  logic              sosc_out_ff;               // Slow oscillator request, registered
  logic [2:0]        isr_ff, imr_ff;            // Sticky events and mask
  logic [15:0]       tick_cnt_ff;               // Sampling divider
  cal_state_e        cal_ff;                    // Calibration sequencer
  // Synchroniser delay lines: en, hv, mask, monitor, fast osc
  logic [4:0]        dly_ff [SYNC_DLY];

  // Decode and qualification
  wire        wr_go    = write_in & ~wait_ff;
  wire        hit_vreg = (address_in == OFS_VREG);
  wire        hit_mon  = (address_in == OFS_MONITOR);
  wire        unlocked = unlock_ff & (unlock_ofs_ff == address_in);
  wire        locked_wr = wr_go & (hit_vreg | hit_mon) & ~unlocked;
  wire        vreg_wr  = wr_go & hit_vreg & unlocked & ~vreg_frz_ff;
  wire        mon_wr   = wr_go & hit_mon & unlocked & ~mon_frz_ff;
  wire        cal_step = (cal_ff == CAL_LOAD);
  wire        vcal_ld  = cal_step & ~vreg_fcd_ff;
  wire        mon_on   = (mon_ctrl_ff != CTRL_OFF);
  wire        samp_req = mon_on & (deep_halt_sleep_in | mon_fs_ff);
  wire [4:0]  dly_in   = {fosc_en_ff, mon_on, hv_mask_ff, hv_en_ff & ~mon_on, vreg_en_ff};
  wire [4:0]  st       = dly_ff[SYNC_DLY-1];
  wire [15:0] tick_top = 16'((32'h1 << mon_rate_ff) - 32'h1);
  wire        tick_end = slow_tick_in & (tick_cnt_ff >= tick_top);
  wire        drop_nxt = mon_on & (samp_req ? (tick_end ? supply_low_in : drop_ff)
                                            : supply_low_in);
  wire [2:0]  evt      = {regulator_good_in & ~good_ff, drop_nxt & ~drop_ff, locked_wr};
  wire [31:0] wd       = writedata_in;
  wire [31:0] vreg_rd  = {vreg_frz_ff, 10'h0, st[2], hv_mask_ff, st[1], hv_en_ff,
                          vreg_fcd_ff, vreg_cal_ff, 3'h0, good_ff, sel_ff, st[0], vreg_en_ff};
  wire [31:0] mon_rd   = {mon_frz_ff, 5'h0, st[3], mon_fcd_ff, mon_cal_ff,
                          4'(0), mon_rate_ff, 3'h0, mon_fs_ff, 2'h0, mon_ctrl_ff};
  wire [31:0] rd_mux   = hit_vreg                      ? vreg_rd :
                         hit_mon                       ? mon_rd :
                         (address_in == OFS_TSENSOR)  ? {31'h0, temp_en_ff} :
                         (address_in == OFS_FAST_OSC) ? {31'h0, st[4]} :
                         (address_in == OFS_SLOW_OSC) ? {31'h0, sosc_en_ff} :
                         (address_in == OFS_PWR_STAT) ? {29'h0, good_ff, drop_ff, 1'b0} :
                         (address_in == OFS_IRQ_MASK) ? {29'h0, imr_ff} :
                         (address_in == OFS_IRQ_STAT) ? {29'h0, isr_ff} : 32'h0;

  // Power-on domain: regulator register and its calibration
  always_ff @(posedge clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      vreg_en_ff  <= 1'b1;
      sel_ff      <= SEL_1V8_RST;
      vreg_cal_ff <= '0;
      vreg_fcd_ff <= 1'b0;
      hv_en_ff    <= 1'b1;
      hv_mask_ff  <= 1'b0;
      vreg_frz_ff <= 1'b0;
    end else if (vcal_ld) begin
      vreg_cal_ff <= fuse_vreg_cal_in;
      vreg_fcd_ff <= 1'b1;
    end else if (vreg_wr) begin
      vreg_en_ff  <= wd[VR_EN];
      sel_ff      <= wd[VR_SEL_LO +: 2];
      vreg_cal_ff <= wd[VR_CAL_LO +: CAL_W];
      vreg_fcd_ff <= wd[VR_FCD];
      hv_en_ff    <= wd[VR_HV_EN];
      hv_mask_ff  <= wd[VR_HV_MSK];
      vreg_frz_ff <= wd[FREEZE_BIT];
    end else if (wake_shutdown_in) begin
      vreg_en_ff  <= 1'b1;
    end
  end

  // Monitor register and monitor calibration
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mon_ctrl_ff <= CTRL_OFF;
      mon_fs_ff   <= 1'b0;
      mon_rate_ff <= '0;
      mon_cal_ff  <= '0;
      mon_fcd_ff  <= 1'b0;
      mon_frz_ff  <= 1'b0;
    end else if (cal_step) begin
      mon_cal_ff  <= fuse_mon_cal_in;
      mon_fcd_ff  <= 1'b1;
    end else if (mon_wr) begin
      mon_ctrl_ff <= wd[SM_CTRL_LO +: 2];
      mon_fs_ff   <= wd[SM_FS];
      mon_rate_ff <= wd[SM_RATE_LO +: RATE_W];
      mon_cal_ff  <= wd[SM_CAL_LO +: CAL_W];
      mon_fcd_ff  <= wd[SM_FCD];
      mon_frz_ff  <= wd[FREEZE_BIT];
    end
  end

  // Unprotected enables and the unlock arm
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      temp_en_ff    <= 1'b0;
      fosc_en_ff    <= 1'b0;
      sosc_en_ff    <= 1'b0;
      unlock_ff     <= 1'b0;
      unlock_ofs_ff <= '0;
    end else if (wr_go) begin
      if (address_in == OFS_TSENSOR) temp_en_ff <= wd[0];
      if (address_in == OFS_FAST_OSC) fosc_en_ff <= wd[0];
      if (address_in == OFS_SLOW_OSC) sosc_en_ff <= wd[0];
      // Any write consumes the arm; a keyed unlock write rearms it
      unlock_ff     <= (address_in == OFS_UNLOCK) && (wd[31:24] == UNLOCK_KEY);
      unlock_ofs_ff <= wd[5:0];
    end
  end

  // Synchronisation delay line, SYNC_DLY stages each carrying all five controlled bits
  for (genvar s = 0; s < SYNC_DLY; s++) begin : g_dly
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) dly_ff[s] <= '0;
      else dly_ff[s] <= (s == 0) ? dly_in : dly_ff[(s == 0) ? 0 : s-1];
    end
  end

  // Calibration sequencer holds the CPU until loads are done
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_ff      <= CAL_LOAD;
      cpu_run_out <= 1'b0;
    end else begin
      case (cal_ff)
        CAL_LOAD: begin
          cal_ff      <= CAL_RUN;
          cpu_run_out <= 1'b1;
        end
        CAL_RUN: cal_ff <= CAL_RUN;
        default: cal_ff <= CAL_LOAD;
      endcase
    end
  end

  // Sampling divider, detect flag, reset and interrupt
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_ff <= '0;
      strobe_ff   <= 1'b0;
      samp_ff     <= 1'b0;
      drop_ff     <= 1'b0;
      good_ff     <= 1'b0;
      hv_eff_ff   <= 1'b1;
      rst_req_ff  <= 1'b0;
      isr_ff      <= '0;
      imr_ff      <= '0;
      irq_ff      <= 1'b0;
      sosc_out_ff <= 1'b0;
    end else begin
      // Slow oscillator runs for software or for sampling
      sosc_out_ff <= sosc_en_ff | samp_req;
      tick_cnt_ff <= (!samp_req || tick_end) ? 16'h0 :
                     slow_tick_in ? tick_cnt_ff + 16'h1 : tick_cnt_ff;
      strobe_ff   <= samp_req & tick_end;
      samp_ff     <= samp_req;
      drop_ff     <= drop_nxt;
      good_ff     <= regulator_good_in;
      hv_eff_ff   <= hv_en_ff & ~mon_on;
      rst_req_ff  <= (drop_ff & (mon_ctrl_ff == CTRL_RESET)) |
                     (hv_trip_in & st[1] & ~st[2]);
      // Set wins over clear for every sticky event
      isr_ff <= (isr_ff & ~((wr_go && address_in == OFS_IRQ_CLR) ? wd[2:0] : 3'h0))
                | evt;
      imr_ff <= (imr_ff | ((wr_go && address_in == OFS_IRQ_EN) ? wd[2:0] : 3'h0))
                & ~((wr_go && address_in == OFS_IRQ_DIS) ? wd[2:0] : 3'h0);
      irq_ff <= |(isr_ff & imr_ff);
    end
  end

  // Avalon slave: one wait cycle, data ready when waitrequest drops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= ~((read_in | write_in) & wait_ff);
      if (read_in && wait_ff) rdata_ff <= rd_mux;
    end
  end

  // Outputs straight from flops
  assign readdata_out            = rdata_ff;
  assign waitrequest_out         = wait_ff;
  assign regulator_en_out        = vreg_en_ff;
  assign output_level_select_out = sel_ff;
  assign vreg_cal_out            = vreg_cal_ff;
  assign hv_detector_en_out      = hv_eff_ff;
  assign monitor_en_out          = st[3];
  assign sampling_mode_out       = samp_ff;
  assign sample_strobe_out       = strobe_ff;
  assign mon_cal_out             = mon_cal_ff;
  assign slow_osc_en_out         = sosc_out_ff;
  assign temp_sensor_en_out      = temp_en_ff;
  assign fast_osc_en_out         = fosc_en_ff;
  assign reset_req_out           = rst_req_ff;
  assign irq_out                 = irq_ff;

  // Checks
  // All checks run on the bus clock
  // Either reset stops every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in || !por_resetn_in);

  a_lock_blocks: assert property (wr_go && hit_vreg && !unlocked |=> $stable(vreg_rd[31:5]))
    else $error("locked regulator write changed it");
  a_vreg_freeze: assert property (vreg_frz_ff && !vcal_ld |=> vreg_frz_ff && $stable(sel_ff))
    else $error("frozen regulator register changed");
  a_mon_freeze: assert property (mon_frz_ff && !cal_step |=> $stable(mon_ctrl_ff))
    else $error("frozen monitor register changed");
  // Started after reset, so the delay line is full of live requests
  a_state_delay: assert property (1'b1 |-> ##SYNC_DLY st == $past(dly_in, SYNC_DLY))
    else $error("state bits do not trail requests");
  // Wake pulse turns the regulator back on
  a_wake_enable: assert property (wake_shutdown_in && !vreg_wr && !vcal_ld |=> vreg_en_ff)
    else $error("wake left regulator off");
  // Good flag follows the analog level
  a_good_follow: assert property (regulator_good_in |=> good_ff)
    else $error("regulator good not reported");
  // Drop flag stays clear while the monitor is off
  a_drop_off: assert property (!mon_on |=> !drop_ff)
    else $error("drop flag set with monitor off");
  // Interrupt line is the masked status one cycle later
  a_irq_line: assert property (1'b1 |=> irq_ff == $past(|(isr_ff & imr_ff)))
    else $error("interrupt line wrong");
  // Monitor calibration marks itself done
  a_mon_fcd: assert property (cal_step |=> mon_fcd_ff)
    else $error("monitor calibration not marked done");
  // Regulator calibration load takes the fuse value
  a_vreg_load: assert property (vcal_ld |=> vreg_fcd_ff && vreg_cal_ff == $past(fuse_vreg_cal_in))
    else $error("regulator calibration not loaded");
  // Temperature sensor bit takes the written value
  a_temp_en: assert property (wr_go && address_in == OFS_TSENSOR |=> temp_en_ff == $past(wd[0]))
    else $error("temperature sensor enable lost");
  a_hv_off_mon: assert property (mon_on |=> !hv_eff_ff)
    else $error("detector left on with monitor");
  a_drop_irq: assert property ($rose(drop_ff) && imr_ff[ST_DROP] |=> irq_ff)
    else $error("drop flag rise gave no interrupt");
  a_drop_reset: assert property (drop_ff && mon_ctrl_ff == CTRL_RESET |=> rst_req_ff)
    else $error("drop did not request reset");
  a_ctrl_two: assert property (mon_ctrl_ff == CTRL_IRQ && !(hv_trip_in && st[1] && !st[2])
                               |=> !rst_req_ff)
    else $error("interrupt-only monitor reset the part");
  a_access_err: assert property (locked_wr |=> isr_ff[ST_ERR])
    else $error("locked write raised no access error");
  // CPU start only after the monitor calibration is in place
  a_cal_done: assert property ($rose(cpu_run_out) |-> mon_fcd_ff)
    else $error("cpu started before calibration");
  a_sample_osc: assert property (samp_ff |-> slow_osc_en_out)
    else $error("sampling without slow oscillator");
  // Slave answers one cycle after taking a request
  a_bus_answer: assert property ((read_in || write_in) && wait_ff |=> !wait_ff)
    else $error("bus answer late");
  // Main scenarios reached
  c_unlock_wr: cover property (vreg_wr ##1 vreg_wr == 1'b0);
  c_sampling: cover property (samp_ff ##[1:200] strobe_ff);
  c_drop_irq: cover property ($rose(drop_ff) ##1 irq_ff);
  c_freeze: cover property (mon_frz_ff && wr_go && hit_mon && unlocked);
endmodule : supply_monitor_regulator_ctrl
`default_nettype wire

/* File: supply_monitor_regulator_ctrl_tb.sv */
// Self-checking testbench for the supply monitor and regulator control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regulator_ctrl_tb;
  import supply_ctrl_pkg::*;
  logic        clk_in, resetn_in, por_resetn_in, read_in, write_in;   // Clock, resets, strobes
  logic [5:0]  address_in;                                            // Byte address
  logic [31:0] writedata_in, readdata_out, rd;                        // Bus data
  logic        waitrequest_out, cpu_run_out, regulator_en_out, hv_detector_en_out;
  logic        monitor_en_out, sampling_mode_out, sample_strobe_out, slow_osc_en_out;
  logic        temp_sensor_en_out, fast_osc_en_out, reset_req_out, irq_out;
  logic [1:0]  output_level_select_out;                               // Level select
  logic [7:0]  fuse_vreg_cal_in, fuse_mon_cal_in, vreg_cal_out, mon_cal_out;
  logic        wake_shutdown_in, regulator_good_in, hv_trip_in, supply_low_in;
  logic        deep_halt_sleep_in, slow_tick_in;                      // Sleep and tick
  int          n_mismatch, n_tests, cycles;                           // Counters
  supply_monitor_regulator_ctrl i_supply_monitor_regulator_ctrl (.clk_in, .resetn_in,
    .por_resetn_in, .address_in, .read_in, .write_in, .writedata_in, .readdata_out,
    .waitrequest_out, .fuse_vreg_cal_in, .fuse_mon_cal_in, .wake_shutdown_in,
    .regulator_good_in, .hv_trip_in, .supply_low_in, .deep_halt_sleep_in, .slow_tick_in,
    .cpu_run_out, .regulator_en_out, .output_level_select_out, .vreg_cal_out,
    .hv_detector_en_out, .monitor_en_out, .sampling_mode_out, .sample_strobe_out,
    .mon_cal_out, .slow_osc_en_out, .temp_sensor_en_out, .fast_osc_en_out,
    .reset_req_out, .irq_out);
  // 25 MHz clock
  always #20 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon access held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= ~wr;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    rd = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clk_in);
  endtask : acc
  // Unlock then write a protected register
  task automatic ulw(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, OFS_UNLOCK, {UNLOCK_KEY, 18'h0, a});
    acc(1'b1, a, d);
  endtask : ulw
  // Wait for state bits to settle
  task automatic settle();
    repeat (SYNC_DLY_RST + 3) @(posedge clk_in);
  endtask : settle
  // Reset values and calibration load
  task automatic t_reset();
    settle();
    chk("cpu_run", 1, cpu_run_out);
    acc(1'b0, OFS_VREG, 0);
    chk("vreg_rst", 32'h00075a13, rd);
    acc(1'b0, OFS_MONITOR, 0);
    chk("mon_rst", 32'h013c0000, rd);
    acc(1'b0, 6'h3c, 0);
    chk("unmapped", 0, rd);
  endtask : t_reset
  // Locked writes and access error interrupt
  task automatic t_lock();
    acc(1'b1, OFS_IRQ_EN, 32'h1);
    acc(1'b1, OFS_IRQ_CLR, 32'h7);
    chk("irq_idle", 0, irq_out);
    acc(1'b1, OFS_VREG, 0);
    acc(1'b0, OFS_VREG, 0);
    chk("vreg_locked", 32'h00075a13, rd);
    acc(1'b1, OFS_MONITOR, 32'h1);
    acc(1'b0, OFS_MONITOR, 0);
    chk("mon_locked", 32'h013c0000, rd);
    acc(1'b0, OFS_IRQ_STAT, 0);
    chk("isr_err", 1, rd & 32'h1);
    chk("irq_err", 1, irq_out);
    acc(1'b1, OFS_IRQ_DIS, 32'h1);
    acc(1'b0, OFS_IRQ_MASK, 0);
    chk("imr_off", 0, rd & 32'h1);
    acc(1'b1, OFS_IRQ_CLR, 32'h7);
  endtask : t_lock
  // Regulator off, calibration override, wake, freeze
  task automatic t_vreg();
    ulw(OFS_VREG, 32'h00037700);
    chk("vreg_en_off", 0, regulator_en_out);
    chk("vreg_cal", 32'h77, vreg_cal_out);
    settle();
    acc(1'b0, OFS_VREG, 0);
    chk("vreg_off", 32'h00077710, rd);
    wake_shutdown_in <= 1'b1;
    @(posedge clk_in);
    wake_shutdown_in <= 1'b0;
    settle();
    chk("vreg_wake", 1, regulator_en_out);
    ulw(OFS_VREG, 32'h80037701);
    ulw(OFS_VREG, 32'h00037700);
    chk("vreg_frozen", 1, regulator_en_out);
    acc(1'b0, OFS_VREG, 0);
    chk("vreg_frz_rd", 32'h80077713, rd);
  endtask : t_vreg
  // Monitor with reset on drop, then interrupt-only with sampling
  task automatic t_mon();
    acc(1'b1, OFS_IRQ_EN, 32'h2);
    ulw(OFS_MONITOR, 32'h003c0001);
    settle();
    chk("mon_on", 1, monitor_en_out);
    chk("hv_off", 0, hv_detector_en_out);
    supply_low_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("reset_req", 1, reset_req_out);
    chk("irq_drop", 1, irq_out);
    acc(1'b0, OFS_PWR_STAT, 0);
    chk("drop_set", 2, rd & 32'h2);
    supply_low_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    acc(1'b0, OFS_PWR_STAT, 0);
    chk("drop_clr", 0, rd & 32'h2);
    acc(1'b1, OFS_IRQ_CLR, 32'h7);
    ulw(OFS_MONITOR, 32'h003c0002);
    deep_halt_sleep_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("samp_deep", 1, sampling_mode_out);
    deep_halt_sleep_in <= 1'b0;
    ulw(OFS_MONITOR, 32'h003c0012);
    repeat (3) @(posedge clk_in);
    chk("samp_force", 1, sampling_mode_out);
    chk("slow_osc", 1, slow_osc_en_out);
    supply_low_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    slow_tick_in <= 1'b1;
    @(posedge clk_in);
    slow_tick_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    acc(1'b0, OFS_PWR_STAT, 0);
    chk("drop_samp", 2, rd & 32'h2);
    chk("no_reset", 0, reset_req_out);
    supply_low_in <= 1'b0;
  endtask : t_mon
  // Temperature sensor and fast oscillator handshake
  task automatic t_osc();
    int n;
    acc(1'b1, OFS_TSENSOR, 32'h1);
    chk("temp_en", 1, temp_sensor_en_out);
    acc(1'b1, OFS_FAST_OSC, 32'h1);
    chk("fast_en", 1, fast_osc_en_out);
    n = 0;
    do acc(1'b0, OFS_FAST_OSC, 0); while (rd[0] !== 1'b1 && ++n < 20);
    chk("fast_rd1", 1, rd & 32'h1);
    acc(1'b1, OFS_FAST_OSC, 32'h0);
    n = 0;
    do acc(1'b0, OFS_FAST_OSC, 0); while (rd[0] !== 1'b0 && ++n < 20);
    chk("fast_rd0", 0, rd & 32'h1);
  endtask : t_osc
  // Non power-on reset keeps regulator settings, reloads monitor
  task automatic t_warm();
    resetn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    acc(1'b0, OFS_VREG, 0);
    chk("vreg_warm", 32'h80077713, rd);
    acc(1'b0, OFS_MONITOR, 0);
    chk("mon_warm", 32'h013c0000, rd);
  endtask : t_warm
  // Main sequence
  initial begin
    {clk_in, read_in, write_in, wake_shutdown_in, hv_trip_in} = '0;
    {supply_low_in, deep_halt_sleep_in, slow_tick_in, resetn_in, por_resetn_in} = '0;
    {address_in, writedata_in, n_mismatch, n_tests, cycles} = '0;
    regulator_good_in = 1'b1;
    fuse_vreg_cal_in = 8'h5a;
    fuse_mon_cal_in = 8'h3c;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    por_resetn_in <= 1'b1;
    t_reset();
    t_lock();
    t_vreg();
    t_mon();
    t_osc();
    t_warm();
    final_report();
  end
endmodule : supply_monitor_regulator_ctrl_tb
`default_nettype wire
